// *** rtl/pwp_cfg.svh ***
`ifndef PWP_CFG_SVH
`define PWP_CFG_SVH

// Register addresses (byte addresses, one word each)
`define PWP_ADDR_TB_CTRL      8'h00
`define PWP_ADDR_GEN_CTRL     8'h04
`define PWP_ADDR_FAULT_CTRL   8'h08
`define PWP_ADDR_PERIOD       8'h0c
`define PWP_ADDR_DUTY         8'h10
`define PWP_ADDR_PHASE        8'h14
`define PWP_ADDR_STATUS       8'h18

// Time base control fields
`define PWP_TB_ENABLE_BIT     15
`define PWP_TB_IDLE_STOP_BIT  13

// Generator control fields
`define PWP_GEN_INDEP_BIT     9
`define PWP_GEN_MODE_LO       2
`define PWP_GEN_MODE_HI       3
`define PWP_GEN_EXT_RST_BIT   1

// Fault and limit control fields
`define PWP_FLT_OVR_LO        0
`define PWP_FLT_OVR_HI        1
`define PWP_FLT_ENABLE_BIT    2
`define PWP_LIM_POL_BIT       9
`define PWP_LIM_SRC_LO        10
`define PWP_LIM_SRC_HI        14

// Reset values
`define PWP_RST_PERIOD        16'hfff8
`define PWP_RST_WORD          16'h0000
`define PWP_RST_MODE          2'h0

// Misc widths
`define PWP_LIM_COUNT         32
`define PWP_DATA_W            16

`endif

// *** rtl/pwp_pkg.sv ***
package pwp_pkg;

  // Output mode of the generator
  typedef enum logic [1:0] {
    PWP_MODE_COMPL,
    PWP_MODE_PUSH_PULL,
    PWP_MODE_INDEP,
    PWP_MODE_RSVD
  } pwp_mode_type;

  // Register bus request bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pwp_bus_type;

  // Pair of pin levels (high side, low side)
  typedef struct packed {
    logic hi;
    logic lo;
  } pwp_pins_type;

endpackage

// *** rtl/pwp_fault_path.sv ***
`timescale 1ns/100ps
`include "pwp_cfg.svh"

// Fault path: purely combinational so it keeps working while the
// gated core clock is stopped in sleep or stopped idle.
module pwp_fault_path (
  // Fault pin and configuration
  input  wire logic                  fault_n,
  input  wire logic                  fault_enable,
  input  wire logic                  module_on,
  // Levels from the gated generator and from the port latches
  input  wire pwp_pkg::pwp_pins_type gen_pins,
  input  wire pwp_pkg::pwp_pins_type gpio_pins,
  input  wire pwp_pkg::pwp_pins_type fault_override_value,
  // Resulting pins and wake request
  output pwp_pkg::pwp_pins_type      pins,
  output logic                       fault_active,
  output logic                       wake_request
);
  import pwp_pkg::*;

  // Fault is a low level on the pin, no clock in the path
  assign fault_active = fault_enable & ~fault_n; // see [RULE_23]

  // Wake request runs alongside the fault interrupt request
  assign wake_request = fault_active; // see [RULE_03]

  // Fault override beats everything, then ownership decides the source
  always_comb begin
    if (fault_active) begin
      pins = fault_override_value; // see [RULE_22] see [RULE_02] see [RULE_07]
    end else if (module_on) begin
      pins = gen_pins;
    end else begin
      pins = gpio_pins; // see [RULE_08]
    end
  end

endmodule

// *** rtl/pwp_generator.sv ***
`timescale 1ns/100ps
`include "pwp_cfg.svh"

// Behaviour
// [RULE_01] Sleep stops time base, outputs hold level
// [RULE_02] Fault low forces override values in sleep
// [RULE_03] Fault during sleep raises wake request
// [RULE_04] Software makes outputs safe before sleep
// [RULE_05] Idle stop bit gates clocks in idle
// [RULE_06] Registers inaccessible while stopped in idle
// [RULE_07] Stopped idle acts like sleep, fault live
// [RULE_08] Idle returns pins to port bits
// [RULE_09] Software disables outputs before idle
// [RULE_10] External reset enable lets signal reset counter
// [RULE_11] Independent select uses own time base
// [RULE_12] No external reset on master base
// [RULE_13] Limit source select picks reset signal
// [RULE_14] Polarity bit picks active reset edge
// [RULE_15] Complementary: low side inverts high side
// [RULE_16] Push-pull alternates sides each period
// [RULE_17] Push-pull phases share one duty
// [RULE_18] Phase offset added to master count
// [RULE_19] Phase offset in all master-base modes
// [RULE_20] Current reset only after duty completes
// [RULE_21] Without reset, period ends at phase value
// [RULE_22] Active fault overrides every other source
// [RULE_23] Fault path independent of gated clock
// [RULE_24] External reset restarts counter, new cycle
module pwp_generator (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  input  wire pwp_pkg::pwp_bus_type  bus,
  output logic [15:0]                rdata,
  // Power-save state of the system
  input  wire logic                  sleep_mode,
  input  wire logic                  idle_mode,
  // Master time base count from the shared timer
  input  wire logic [15:0]           master_count,
  // Current-limit comparator inputs
  input  wire logic [31:0]           limit_in,
  // Fault pin, active low
  input  wire logic                  fault_n,
  // Port latches sharing the pins
  input  wire pwp_pkg::pwp_pins_type gpio_pins,
  // Pins and core signals
  output pwp_pkg::pwp_pins_type      pins,
  output logic                       fault_active,
  output logic                       wake_request
);
  import pwp_pkg::*;

  // Software registers
  logic [15:0]           timebase_control;    // Enable, idle stop
  logic [15:0]           generator_control;   // Mode, independent, ext reset
  logic [15:0]           fault_limit_control; // Fault data, limit source
  logic [15:0]           period;              // Master period (unused locally)
  logic [15:0]           duty;                // Duty value
  logic [15:0]           phase_offset;        // Phase or independent period

  // Generator state
  logic [15:0]           local_count;         // Independent time base
  logic                  push_side;           // Push-pull: 0 high, 1 low
  logic                  limit_prev;          // Previous limit sample
  logic [15:0]           prev_eff;            // Previous effective count
  pwp_pins_type          gen_pins;            // Registered generator levels

  // Decoded controls
  logic                  tb_enable;
  logic                  idle_stop_select;
  logic                  independent_base_select;
  logic                  external_reset_enable;
  logic [4:0]            limit_source_select;
  logic                  limit_edge_polarity;
  pwp_mode_type          mode;
  pwp_pins_type          fault_override_value;
  logic                  fault_enable;

  // Derived state
  logic                  core_run;            // Gated module clock enable
  logic                  module_on;           // PWM owns the pins
  logic                  reg_access;          // Registers reachable
  logic [15:0]           eff_count;           // Count fed to the comparator
  logic                  period_start;        // Count just wrapped or restarted
  logic                  limit_sel;
  logic                  limit_edge;
  logic                  ext_reset;
  logic                  pulse;               // Raw comparator output
  logic [15:0]           next_local_count;
  pwp_pins_type          next_gen_pins;

  assign tb_enable               = timebase_control[`PWP_TB_ENABLE_BIT];
  assign idle_stop_select        = timebase_control[`PWP_TB_IDLE_STOP_BIT];
  assign independent_base_select = generator_control[`PWP_GEN_INDEP_BIT];
  assign external_reset_enable   = generator_control[`PWP_GEN_EXT_RST_BIT];
  assign mode = pwp_mode_type'(generator_control[`PWP_GEN_MODE_HI:`PWP_GEN_MODE_LO]);
  assign limit_source_select = fault_limit_control[`PWP_LIM_SRC_HI:`PWP_LIM_SRC_LO];
  assign limit_edge_polarity = fault_limit_control[`PWP_LIM_POL_BIT];
  assign fault_override_value = fault_limit_control[`PWP_FLT_OVR_HI:`PWP_FLT_OVR_LO];
  assign fault_enable         = fault_limit_control[`PWP_FLT_ENABLE_BIT];

  // Core stops in sleep, and in idle only when idle stop is selected
  assign core_run = ~sleep_mode & ~(idle_mode & idle_stop_select); // see [RULE_01] see [RULE_05]

  // Any idle hands the pins back to the port bits
  assign module_on = tb_enable & ~idle_mode; // see [RULE_08]

  // Stopped idle (and sleep) cuts the registers off from the core
  assign reg_access = core_run; // see [RULE_06]

  // Rising/falling compare of selected limit line
  assign limit_sel  = limit_in[limit_source_select]; // see [RULE_13]
  // Polarity 0 chooses rising, 1 chooses falling
  assign limit_edge = limit_edge_polarity ? (limit_prev & ~limit_sel)
                                          : (~limit_prev & limit_sel); // see [RULE_14]

  // Reset honoured only in independent mode and after duty is done;
  // on the master base the combination is undefined, so it is ignored
  assign ext_reset = external_reset_enable & independent_base_select & limit_edge
                     & (local_count >= duty); // see [RULE_10] see [RULE_20] see [RULE_12]

  // Independent count wraps at the phase register value
  always_comb begin
    if (ext_reset) begin
      next_local_count = 16'h0000; // see [RULE_24]
    end else if (local_count >= phase_offset) begin
      next_local_count = 16'h0000; // see [RULE_21]
    end else begin
      next_local_count = local_count + 16'h0001;
    end
  end

  // Count the comparator sees: own base, or master plus phase
  assign eff_count = independent_base_select ? local_count          // see [RULE_11]
                                             : master_count + phase_offset; // see [RULE_18] see [RULE_19]

  // A new period starts when the count goes back below its old value or is zero
  assign period_start = (eff_count < prev_eff) || (eff_count == 16'h0000);

  // Edge-aligned comparator, same duty for every side
  assign pulse = eff_count < duty; // see [RULE_17]

  // Route the pulse according to output mode
  always_comb begin
    unique case (mode)
      PWP_MODE_COMPL: begin
        next_gen_pins.hi = pulse;
        next_gen_pins.lo = ~pulse; // see [RULE_15]
      end
      PWP_MODE_PUSH_PULL: begin
        // Only one side fires, the other rests low; the side flips on the
        // start cycle itself so no period is split across both pins
        next_gen_pins.hi = pulse & ~(push_side ^ period_start); // see [RULE_16]
        next_gen_pins.lo = pulse & (push_side ^ period_start);  // see [RULE_16]
      end
      default: begin
        next_gen_pins.hi = pulse;
        next_gen_pins.lo = pulse;
      end
    endcase
  end

  // Register writes, only while the core clock runs
  always_ff @(posedge clk) begin
    if (rst) begin
      timebase_control    <= `PWP_RST_WORD;
      generator_control   <= `PWP_RST_WORD;
      fault_limit_control <= `PWP_RST_WORD;
      period              <= `PWP_RST_PERIOD;
      duty                <= `PWP_RST_WORD;
      phase_offset        <= `PWP_RST_WORD;
    end else if (bus.wr && reg_access) begin // see [RULE_06]
      unique case (bus.addr)
        `PWP_ADDR_TB_CTRL:    timebase_control    <= bus.wdata;
        `PWP_ADDR_GEN_CTRL:   generator_control   <= bus.wdata;
        `PWP_ADDR_FAULT_CTRL: fault_limit_control <= bus.wdata;
        `PWP_ADDR_PERIOD:     period              <= bus.wdata;
        `PWP_ADDR_DUTY:       duty                <= bus.wdata;
        `PWP_ADDR_PHASE:      phase_offset        <= bus.wdata;
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; zero when blocked or unmapped
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `PWP_RST_WORD;
    end else if (bus.rd && reg_access) begin
      unique case (bus.addr)
        `PWP_ADDR_TB_CTRL:    rdata <= timebase_control;
        `PWP_ADDR_GEN_CTRL:   rdata <= generator_control;
        `PWP_ADDR_FAULT_CTRL: rdata <= fault_limit_control;
        `PWP_ADDR_PERIOD:     rdata <= period;
        `PWP_ADDR_DUTY:       rdata <= duty;
        `PWP_ADDR_PHASE:      rdata <= phase_offset;
        `PWP_ADDR_STATUS:     rdata <= {11'h000, push_side, fault_active,
                                        module_on, gen_pins};
        default:              rdata <= `PWP_RST_WORD;
      endcase
    end else begin
      rdata <= `PWP_RST_WORD;
    end
  end

  // Independent time base; frozen whenever the core clock is gated
  always_ff @(posedge clk) begin
    if (rst) begin
      local_count <= `PWP_RST_WORD;
    end else if (core_run && tb_enable) begin // see [RULE_01]
      local_count <= next_local_count;
    end
  end

  // Limit edge history, sampled only with the running core
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_prev <= 1'b0;
      prev_eff   <= `PWP_RST_WORD;
    end else if (core_run && tb_enable) begin
      limit_prev <= limit_sel;
      prev_eff   <= eff_count;
    end
  end

  // Push-pull side flips at each new period
  always_ff @(posedge clk) begin
    if (rst) begin
      push_side <= 1'b0;
    end else if (core_run && tb_enable && period_start) begin
      push_side <= ~push_side; // see [RULE_16]
    end
  end

  // Output levels hold their last value while the core is stopped
  always_ff @(posedge clk) begin
    if (rst) begin
      gen_pins <= `PWP_RST_MODE;
    end else if (core_run && tb_enable) begin // see [RULE_01]
      gen_pins <= next_gen_pins;
    end
  end

  // Clock-free fault path and pin ownership
  pwp_fault_path u_fault (
    .fault_n              (fault_n),
    .fault_enable         (fault_enable),
    .module_on            (module_on),
    .gen_pins             (gen_pins),
    .gpio_pins            (gpio_pins),
    .fault_override_value (fault_override_value),
    .pins                 (pins),
    .fault_active         (fault_active),
    .wake_request         (wake_request)
  );

endmodule

// *** dv/pwp_chk.sv ***
`timescale 1ns/100ps
`include "pwp_cfg.svh"

// Port-level checker for the generator; shadows the few control words it needs
module pwp_chk (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Register port
  input wire pwp_pkg::pwp_bus_type  bus,
  input wire logic [15:0]           rdata,
  // Power state and inputs
  input wire logic                  sleep_mode,
  input wire logic                  idle_mode,
  input wire logic [15:0]           master_count,
  input wire logic [31:0]           limit_in,
  input wire logic                  fault_n,
  input wire pwp_pkg::pwp_pins_type gpio_pins,
  // Design outputs
  input wire pwp_pkg::pwp_pins_type pins,
  input wire logic                  fault_active,
  input wire logic                  wake_request
);
  import pwp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] tb_q, gen_q, flt_q, duty_q, ph_q; // Shadows of accepted writes
  logic        stopped;                          // Core clock gated
  logic        run;                              // Master base running, pins visible
  logic        run_c;                            // Same, complementary mode
  logic [15:0] eff;                              // Shifted master count
  assign stopped = sleep_mode | (idle_mode & tb_q[13]);
  assign run = tb_q[15] & ~sleep_mode & ~idle_mode & ~fault_active & ~gen_q[9];
  assign run_c = run & (gen_q[3:2] == 2'h0);
  assign eff = master_count + ph_q;
  // Shadow writes the way the core takes them; refused while stopped
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_q <= 16'h0; gen_q <= 16'h0; flt_q <= 16'h0; duty_q <= 16'h0; ph_q <= 16'h0;
    end else if (bus.wr && !stopped) begin
      case (bus.addr)
        `PWP_ADDR_TB_CTRL:    tb_q <= bus.wdata;
        `PWP_ADDR_GEN_CTRL:   gen_q <= bus.wdata;
        `PWP_ADDR_FAULT_CTRL: flt_q <= bus.wdata;
        `PWP_ADDR_DUTY:       duty_q <= bus.wdata;
        `PWP_ADDR_PHASE:      ph_q <= bus.wdata;
        default:              tb_q <= tb_q;
      endcase
    end
  end
  // Three steady cycles cover the one-cycle pin register after a change
  sequence s_comp_steady; run_c [*3]; endsequence
  sequence s_sleep_hold; (sleep_mode && !idle_mode && !fault_active) [*2]; endsequence
  AST_FAULT_OVR: assert property (fault_active |-> {pins.hi, pins.lo} == flt_q[1:0])
    else $error("fault override not on pins");
  AST_FAULT_CAUSE: assert property (fault_active == (flt_q[2] && !fault_n))
    else $error("fault flag does not follow pin");
  AST_WAKE: assert property (wake_request == (flt_q[2] && !fault_n))
    else $error("wake request does not follow fault");
  AST_SLEEP_HOLD: assert property (s_sleep_hold |-> $stable(pins))
    else $error("pins moved during sleep");
  AST_IDLE_PORT: assert property (idle_mode && !fault_active |-> pins == gpio_pins)
    else $error("pins not owned by port in idle");
  AST_STOP_READ: assert property (bus.rd && stopped |=> rdata == 16'h0)
    else $error("read answered while stopped");
  AST_COMPL: assert property (s_comp_steady |-> pins.lo == !pins.hi)
    else $error("low side not inverse of high side");
  AST_PHASE: assert property (s_comp_steady |-> pins.hi == $past(eff < duty_q))
    else $error("high side not from shifted count");
  AST_PP_EXCL: assert property ((run && gen_q[3:2] == 2'h1) [*2] |-> !(pins.hi && pins.lo))
    else $error("both sides on in push-pull");
endmodule

// *** dv/pwp_stage_model.sv ***
`timescale 1ns/100ps

// Power stage with a current comparator on one limit line and a fault pin
module pwp_stage_model #(
  parameter int DELAY = 3                       // Cycles of decay before the trip
) (
  // Clock
  input  wire logic                  clk,
  // Switch drive from the generator
  input  wire pwp_pkg::pwp_pins_type pins,
  // Bench controls
  input  wire logic [4:0]            line_sel,
  input  wire logic                  fault_cmd,
  // Comparator lines and fault pin
  output logic [31:0]                limit_in,
  output logic                       fault_n
);
  int low_cnt = 0;                               // Cycles since high switch opened
  // Current decays only while the high switch is off; saturate to stay bounded
  always_ff @(posedge clk) begin
    if (pins.hi) begin
      low_cnt <= 0;
    end else if (low_cnt < 1000) begin
      low_cnt <= low_cnt + 1;
    end
  end
  // Comparator level: rises after the decay, falls when the switch closes again
  assign limit_in = (low_cnt >= DELAY) ? (32'h1 << line_sel) : 32'h0;
  assign fault_n = !fault_cmd;
endmodule

// *** dv/pwp_power_save_and_ext_reset_tb.sv ***
`timescale 1ns/100ps
`include "pwp_cfg.svh"

module pwp_power_save_and_ext_reset_tb;
  import pwp_pkg::*;
  typedef struct packed {
    logic [15:0] ph, du, mc;
    logic [1:0]  mode;
    logic        hi, lo;
  } pwp_row_type;
  logic clk = 1'b0;                             // 250 MHz system clock
  logic rst, sleep_mode, idle_mode, fault_cmd;  // Bench controls
  pwp_bus_type bus;                             // Register requests
  logic [15:0] rdata, master_count, v;
  logic [31:0] limit_in;
  logic [4:0] line_sel;
  logic fault_n, fault_active, wake_request;
  pwp_pins_type gpio_pins, pins;
  pwp_pins_type pp_first, pp_second;            // Push-pull pins seen in two periods
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int p, hi_n, lo_n;
  pwp_row_type rows [7] = '{'{16'h0, 16'ha, 16'h9, 2'h0, 1'b1, 1'b0},
    '{16'h0, 16'ha, 16'ha, 2'h0, 1'b0, 1'b1}, '{16'h5, 16'ha, 16'h4, 2'h0, 1'b1, 1'b0},
    '{16'h5, 16'ha, 16'h5, 2'h0, 1'b0, 1'b1}, '{16'hfffe, 16'ha, 16'h3, 2'h0, 1'b1, 1'b0},
    '{16'h6, 16'h4, 16'h0, 2'h2, 1'b0, 1'b0}, '{16'h6, 16'h8, 16'h1, 2'h2, 1'b1, 1'b1}};
  always #2 clk = ~clk;
  pwp_generator dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .master_count(master_count), .limit_in(limit_in),
    .fault_n(fault_n), .gpio_pins(gpio_pins), .pins(pins), .fault_active(fault_active),
    .wake_request(wake_request));
  pwp_stage_model #(.DELAY(3)) stage (.clk(clk), .pins(pins), .line_sel(line_sel),
    .fault_cmd(fault_cmd), .limit_in(limit_in), .fault_n(fault_n));
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Cycles between two rising edges of the high side, taken on the second period
  task automatic measure(output int per);
    repeat (2) begin
      per = 0;
      while (pins.hi !== 1'b1 && per < 100) begin step(1); per++; end
      per = 0;
      while (pins.hi !== 1'b0 && per < 100) begin step(1); per++; end
      while (pins.hi !== 1'b1 && per < 100) begin step(1); per++; end
    end
  endtask
  // Hang guard: the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    bus = '0;
    {rst, sleep_mode, idle_mode, fault_cmd} = 4'h8;
    master_count = 16'h0;
    gpio_pins = 2'h1;
    line_sel = 5'h3;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`PWP_ADDR_PERIOD, v); check("period_reset", 32'(v), 32'hfff8);
    rd(`PWP_ADDR_TB_CTRL, v); check("tb_ctrl_reset", 32'(v), 32'h0);
    rd(8'h1c, v); check("unmapped_read", 32'(v), 32'h0);
    check("pins_off", 32'(pins), 32'h1);
    // Master base rows, shifted count against duty
    foreach (rows[i]) begin
      wr(`PWP_ADDR_PHASE, rows[i].ph);
      wr(`PWP_ADDR_DUTY, rows[i].du);
      wr(`PWP_ADDR_GEN_CTRL, {12'h0, rows[i].mode, 2'h0});
      master_count <= rows[i].mc;
      wr(`PWP_ADDR_TB_CTRL, 16'h8000);
      step(3);
      check("row_hi", 32'(pins.hi), 32'(rows[i].hi));
      check("row_lo", 32'(pins.lo), 32'(rows[i].lo));
      wr(`PWP_ADDR_TB_CTRL, 16'h0);
    end
    // Push-pull: two periods, equal pulses on alternate sides
    wr(`PWP_ADDR_PHASE, 16'h0);
    wr(`PWP_ADDR_DUTY, 16'h4);
    wr(`PWP_ADDR_GEN_CTRL, 16'h0004);
    master_count <= 16'h7;
    wr(`PWP_ADDR_TB_CTRL, 16'h8000);
    {hi_n, lo_n} = 64'h0;
    for (int i = 0; i < 18; i++) begin
      @(posedge clk);
      master_count <= (i < 16) ? 16'(i % 8) : 16'h7;
      #1 hi_n += 32'(pins.hi);
      lo_n += 32'(pins.lo);
      if (i == 1) pp_first = pins;
      if (i == 9) pp_second = pins;
      if (i == 4) check("pp_side_held", 32'(pins), 32'(pp_first));
      if (i == 12) check("pp_side_held", 32'(pins), 32'(pp_second));
    end
    check("pp_alternate", 32'(pp_first ^ pp_second), 32'h3);
    check("pp_hi_count", 32'(hi_n), 32'h4);
    check("pp_lo_count", 32'(lo_n), 32'h4);
    // Sleep freezes pins; fault still overrides and wakes
    wr(`PWP_ADDR_GEN_CTRL, 16'h0);
    wr(`PWP_ADDR_DUTY, 16'h8);
    wr(`PWP_ADDR_FAULT_CTRL, 16'h0005); // safe overrides armed before sleep
    master_count <= 16'h3;
    step(3);
    sleep_mode <= 1'b1;
    master_count <= 16'h14;
    step(4);
    check("sleep_hold", 32'(pins), 32'h2);
    fault_cmd <= 1'b1;
    step(1);
    check("sleep_fault_pins", 32'(pins), 32'h1);
    check("sleep_wake", 32'(wake_request), 32'h1);
    fault_cmd <= 1'b0;
    sleep_mode <= 1'b0;
    // Idle running: port owns pins, registers reachable
    idle_mode <= 1'b1;
    gpio_pins <= 2'h2;
    rd(`PWP_ADDR_DUTY, v); check("idle_run_read", 32'(v), 32'h8);
    check("idle_pins", 32'(pins), 32'h2);
    idle_mode <= 1'b0;
    wr(`PWP_ADDR_TB_CTRL, 16'h2000); // outputs off before idle
    idle_mode <= 1'b1;
    rd(`PWP_ADDR_DUTY, v); check("idle_stop_read", 32'(v), 32'h0);
    wr(`PWP_ADDR_DUTY, 16'h3);
    fault_cmd <= 1'b1;
    step(1);
    check("idle_fault_pins", 32'(pins), 32'h1);
    fault_cmd <= 1'b0;
    idle_mode <= 1'b0;
    rd(`PWP_ADDR_DUTY, v); check("idle_write_refused", 32'(v), 32'h8);
    // Independent base, period 21, external reset from limit line 3
    wr(`PWP_ADDR_GEN_CTRL, 16'h0202);
    wr(`PWP_ADDR_PHASE, 16'h14);
    wr(`PWP_ADDR_DUTY, 16'h5);
    wr(`PWP_ADDR_FAULT_CTRL, 16'h0c00);
    wr(`PWP_ADDR_TB_CTRL, 16'h8000);
    measure(p);
    check("ext_reset_short", 32'(p > 7 && p < 21), 32'h1);
    wr(`PWP_ADDR_FAULT_CTRL, 16'h1000);
    measure(p);
    check("other_source", 32'(p), 32'd21);
    wr(`PWP_ADDR_FAULT_CTRL, 16'h0e00);
    measure(p);
    check("falling_in_duty", 32'(p), 32'd21);
    // Mid-run reset: registers back to reset values, pins back to the port
    rst <= 1'b1;
    step(2);
    rst <= 1'b0;
    rd(`PWP_ADDR_PHASE, v); check("phase_after_reset", 32'(v), 32'h0);
    rd(`PWP_ADDR_PERIOD, v); check("period_after_reset", 32'(v), 32'hfff8);
    rd(`PWP_ADDR_STATUS, v); check("status_after_reset", 32'(v), 32'h0);
    check("pins_after_reset", 32'(pins), 32'h2);
    complete_run();
  end
endmodule

bind pwp_generator pwp_chk chk_i (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .sleep_mode(sleep_mode), .idle_mode(idle_mode), .master_count(master_count),
  .limit_in(limit_in), .fault_n(fault_n), .gpio_pins(gpio_pins), .pins(pins),
  .fault_active(fault_active), .wake_request(wake_request));
